// [test_hub_eeprom_config_decoder.sv]
`default_nettype none
module test_hub_eeprom_config_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  import ucfg_pkg::*;
  // ---------------------------------------------------------
  // Signals
  // ---------------------------------------------------------
  logic clock, sys_rst, fetchValid, descReq, descAccept, descStall;
  logic cfgReady, imageWriteLock, stringsOn, regWr, regRd, slowMode;
  logic [7:0] fetchData, descType, regAddr;
  logic [9:0] mfrTableBase, tableStride;
  logic [3:0] physRemovable;
  logic [31:0] regWdata, regRdata, d;
  ucfg_fetch_t fetch;
  ucfg_desc_t desc;
  logic [7:0] im [24];
  int miscompares = 0;
  int checks = 0;
  ucfg_loader i_ucfg_loader (.clock(clock), .sys_rst(sys_rst),
    .fetch(fetch), .fetchValid(fetchValid), .fetchData(fetchData),
    .descReq(descReq), .descType(descType), .descAccept(descAccept),
    .descStall(descStall), .desc(desc), .cfgReady(cfgReady),
    .imageWriteLock(imageWriteLock), .stringsOn(stringsOn),
    .mfrTableBase(mfrTableBase), .tableStride(tableStride),
    .physRemovable(physRemovable), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata));
  ucfg_eeprom_model i_ucfg_eeprom_model (.clock(clock),
    .sys_rst(sys_rst), .fetch(fetch), .slowMode(slowMode),
    .fetchValid(fetchValid), .fetchData(fetchData));
  // ---------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic start(logic slow);
    @(posedge clock);
    sys_rst  <= 1'b1;
    slowMode <= slow;
    for (int i = 0; i < 24; i++)
      i_ucfg_eeprom_model.mem[i] = im[i];
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    for (int n = 0; n < 400 && cfgReady !== 1'b1; n++)
      @(posedge clock);
    @(posedge clock);
    #1;
    chk("ready", 32'h1, cfgReady);
  endtask
  task automatic reg_wr(logic [7:0] a, logic [31:0] v);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  task automatic reg_rd(logic [7:0] a);
    @(posedge clock);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic desc_chk(logic [7:0] t, logic acc);
    @(posedge clock);
    descReq  <= 1'b1;
    descType <= t;
    @(posedge clock);
    descReq <= 1'b0;
    #1 chk("accept", {31'h0, acc}, {31'h0, descAccept});
    chk("stall", {31'h0, !acc}, {31'h0, descStall});
  endtask
  // ---------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------
  task automatic test_short();
    im = '{8'hd2, 8'h34, 8'h12, 8'h78, 8'h56, 8'ha5, 8'h9a, 8'h3c, 8'h92,
      8'h31, 8'h44, 8'h0a, 8'hf0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    start(1'b0);
    chk("vendor", 32'h1234, desc.vendorId);
    chk("product", 32'h5678, desc.productId);
    chk("release", 32'h9a, desc.releaseHi);
    chk("filters", 32'h3c, {desc.liveOcFilterMs, desc.idleOcFilterMs});
    chk("usable", 32'h9, desc.usablePortMask);
    chk("count", 32'h2, desc.portCount);
    chk("removable", 32'h8, physRemovable);
    chk("pgood", 32'h0a, desc.portPowerGoodDelay);
    chk("chars", 32'h0d, {desc.hubChars[7], desc.hubChars[4:0]});
    chk("fsonly", 32'h1, desc.fsRestrict);
    chk("indoff", 32'h1, desc.indicatorsOff);
    desc_chk(ZERO_DESC, 1'b1);
    desc_chk(HUB_DESC, 1'b1);
    desc_chk(8'h05, 1'b0);
    reg_rd(REG_IDS);
    chk("ids", 32'h56781234, d);
    reg_wr(REG_CTRL, 32'h2);
    reg_rd(REG_POWER);
    chk("power", 32'h9a0a4431, d);
    reg_rd(8'h3c);
    chk("unmapped", 32'h0, d);
  endtask
  task automatic test_ext();
    im = '{8'hd4, 8'h21, 8'h43, 8'h65, 8'h87, 8'h00, 8'hbc, 8'h5a, 8'h11,
      8'h22, 8'h00, 8'h00, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h04,
      8'h83, 8'h42, 8'h1f, 8'h00, 8'h0e, 8'h01};
    start(1'b1);
    chk("vendor", 32'h4321, desc.vendorId);
    chk("count", 32'h3, desc.portCount);
    chk("removable", 32'h2, physRemovable);
    chk("chars", 32'h38, {desc.hubChars[7], desc.hubChars[4:0]});
    chk("leds", 32'h2, {desc.amberLedPolarity, desc.greenLedPolarity});
    chk("lock", 32'h1, imageWriteLock);
    chk("strings", 32'h1, stringsOn);
    chk("base", 32'h56, mfrTableBase);
    chk("stride", 32'h3e, tableStride);
    desc_chk(ZERO_DESC, 1'b0);
    reg_wr(REG_CTRL, 32'h6);
    reg_rd(REG_POWER);
    chk("power hs", 32'hbc776622, d);
    reg_wr(REG_CTRL, 32'h4);
    reg_rd(REG_POWER);
    chk("power fs", 32'hbc775511, d);
    reg_rd(REG_STATUS);
    chk("status", 32'h3a, d[5:0]);
    for (int i = 0; i < 2; i++)
    begin
      im[19] = 8'h41;
      im[20] = i ? 8'h20 : 8'h00;
      start(1'b0);
      chk("strings off", 32'h0, stringsOn);
      chk("unlocked", 32'h0, imageWriteLock);
    end
  endtask
  task automatic test_blank();
    im[0] = 8'hff;
    start(1'b1);
    chk("filters", 32'h88, {desc.liveOcFilterMs, desc.idleOcFilterMs});
    chk("count", 32'h4, desc.portCount);
    chk("up", 32'h28, desc.upstreamCurrentUnits);
    chk("ctrl", 32'h50, desc.controllerCurrentMa);
    chk("pgood", 32'h32, desc.portPowerGoodDelay);
    desc_chk(ZERO_DESC, 1'b1);
  endtask
  // ---------------------------------------------------------
  // Run
  // ---------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Five loads take well under 1,500 cycles; allow generous slack.
  initial
  begin
    #(6000 * 50);
    miscompares++;
    end_sim();
  end
  initial
  begin
    sys_rst = 1'b1;
    slowMode = 1'b0;
    descReq = 1'b0;
    descType = 8'h00;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    test_short();
    test_ext();
    test_blank();
    end_sim();
  end
endmodule
`default_nettype wire

// [ucfg_eeprom_model.sv]
`default_nettype none
module ucfg_eeprom_model
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  // Fetch side
  input  wire ucfg_pkg::ucfg_fetch_t fetch,
  input  wire logic                  slowMode,
  output logic                       fetchValid,
  output logic [7:0]                 fetchData
);
  import ucfg_pkg::*;
  logic [7:0] mem [0:255];
  logic [7:0] addrHeld;
  logic [2:0] waitCnt;
  logic       busy;
  // Outside a reply the data lines toggle, so stale bytes never look valid.
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy       <= 1'b0;
      fetchValid <= 1'b0;
      fetchData  <= 8'h5a;
      addrHeld   <= 8'h00;
      waitCnt    <= 3'h0;
    end
    else
    begin
      fetchValid <= 1'b0;
      fetchData  <= ~fetchData;
      if (fetch.req)
      begin
        busy     <= 1'b1;
        addrHeld <= fetch.addr;
        waitCnt  <= slowMode ? 3'h4 : 3'h0;
      end
      else if (busy && waitCnt == 3'h0)
      begin
        busy       <= 1'b0;
        fetchValid <= 1'b1;
        fetchData  <= mem[addrHeld];
      end
      else if (busy)
        waitCnt <= waitCnt - 3'h1;
    end
  end
endmodule
`default_nettype wire

// [ucfg_loader.sv]
// Decided for this implementation: the address-and-strobe port and the register offsets.
`default_nettype none
// Functional notes
// [RULE1] Byte 0 equal to 0xd2 selects the short image layout.
// [RULE2] Vendor id is byte 1 low, byte 2 high; byte 5 ignored.
// [RULE3] Product id is byte 3 low, byte 4 high.
// [RULE4] Byte 6 is the release id high byte.
// [RULE5] Byte 7 nibbles give live and idle overcurrent filters, default 0x88.
// [RULE6] Byte 8 high nibble marks usable ports, default 0xff.
// [RULE7] Reported port count equals the number of usable port bits.
// [RULE8] Usable ports numbered consecutively; low nibble flags removable ports.
// [RULE9] Byte 9 is upstream current in 2 mA units, defaults 0x28/0x57.
// [RULE10] Byte 10 is controller current in mA, defaults 0x50/0xae.
// [RULE11] Byte 11 is power-good delay in 2 ms units, default 0x32.
// [RULE12] Option bit 7 accepts descriptor type 0x00, else the request stalls.
// [RULE13] Option bit 6 compound flag goes to hub characteristics bit 2.
// [RULE14] Option bit 5 restricts the hub to full speed.
// [RULE15] Option bit 4 turns indicators off and clears characteristics bit 7.
// [RULE16] Option bit 2 ganged power sets characteristics bits 4,3,1,0; in the extended layout the code takes bits 4,3 from byte 18 instead.
// [RULE17] Image writers keep option bits 3, 1 and 0 at zero.
// [RULE18] Byte 0 equal to 0xd4 selects the extended layout.
// [RULE19] Extended byte 18 gives indicator, power and overcurrent polarities.
// [RULE20] Extended byte 19 equal to 0x42 locks out further image writes.
// [RULE21] Language count zero or above 31 disables string support.
// [RULE22] Language codes at 24, pointer arrays follow, each 2N bytes.
// [RULE23] Image read from byte 0 after reset; unknown signature gives defaults.
// [RULE24] Decoded values held until next reset; descriptors built from them. The code also reloads the image on a REG_CTRL reload write.
module ucfg_loader
(
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  // Image byte fetch
  output ucfg_pkg::ucfg_fetch_t         fetch,
  input  wire logic                     fetchValid,
  input  wire logic [7:0]               fetchData,
  // Descriptor request check
  input  wire logic                     descReq,
  input  wire logic [7:0]               descType,
  output logic                          descAccept,
  output logic                          descStall,
  // Decoded configuration
  output ucfg_pkg::ucfg_desc_t          desc,
  output logic                          cfgReady,
  output logic                          imageWriteLock,
  output logic                          stringsOn,
  output logic [9:0]                    mfrTableBase,
  output logic [9:0]                    tableStride,
  output logic [3:0]                    physRemovable,
  // Register port
  input  wire logic [7:0]               regAddr,
  input  wire logic [31:0]              regWdata,
  input  wire logic                     regWr,
  input  wire logic                     regRd,
  output logic [31:0]                   regRdata
);
  import ucfg_pkg::*;

  typedef enum logic [2:0]
  {
    ST_FETCH = 3'b001,
    ST_WAIT  = 3'b010,
    ST_DONE  = 3'b100
  } ucfg_state_t;

  // -------------------------------------------------------------
  // Image store and load sequencer
  // -------------------------------------------------------------
  logic [7:0]  img_r [IMG_BYTES];
  ucfg_state_t state_r;
  ucfg_state_t state_nxt;
  logic [7:0]  ptr_r;
  ucfg_fmt_t   fmt_r;
  logic [2:0]  ctrl_r;
  logic        reload;

  assign reload = regWr && regAddr == REG_CTRL && regWdata[CTRL_RELOAD];

  function automatic logic [7:0] lastByte(input logic [7:0] sig);
    if (sig == SIG_EXT)
      lastByte = LAST_EXT;
    else
      lastByte = LAST_SHORT;
  endfunction

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_FETCH: state_nxt = ST_WAIT;
      ST_WAIT:
      begin
        if (fetchValid)
        begin
          // A bad signature ends the load at once.
          if (ptr_r == 8'h00 && fetchData != SIG_SHORT
              && fetchData != SIG_EXT)
            state_nxt = ST_DONE; // RULE23
          else if (ptr_r == lastByte(img_r[0]) && ptr_r != 8'h00)
            state_nxt = ST_DONE;
          else
            state_nxt = ST_FETCH;
        end
      end
      ST_DONE:
      begin
        if (reload)
          state_nxt = ST_FETCH;
      end
      default: state_nxt = ST_FETCH;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      state_r <= ST_FETCH;
    else
      state_r <= state_nxt;
  end

  // Bytes are taken strictly in order from byte 0.
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      ptr_r <= 8'h00; // RULE23
    else if (state_r == ST_DONE)
      ptr_r <= 8'h00;
    else if (state_r == ST_WAIT && fetchValid)
      ptr_r <= ptr_r + 8'h01;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      fetch <= '0;
    else
    begin
      fetch.req <= state_r == ST_FETCH;
      if (state_r == ST_FETCH)
        fetch.addr <= ptr_r;
    end
  end

  // The store only changes during a load, so the fields derived from it alone stay
  // put until reset or a software reload; extended-layout current fields also follow ctrl_r.
  always_ff @(posedge clock)
  begin
    if (state_r == ST_WAIT && fetchValid && ptr_r < 8'(IMG_BYTES))
      img_r[ptr_r[4:0]] <= fetchData; // RULE24
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      fmt_r <= FMT_NONE;
    else if (state_r == ST_WAIT && fetchValid && ptr_r == 8'h00)
    begin
      if (fetchData == SIG_SHORT)
        fmt_r <= FMT_SHORT; // RULE1
      else if (fetchData == SIG_EXT)
        fmt_r <= FMT_EXT; // RULE18
      else
        fmt_r <= FMT_NONE;
    end
  end

  // -------------------------------------------------------------
  // Field decode
  // -------------------------------------------------------------
  logic        isShort;
  logic        isExt;
  logic        speedHs;
  logic [7:0]  optByte;
  logic [7:0]  polByte;
  logic [7:0]  ocByte;
  logic [7:0]  portByte;
  logic [7:0]  langCnt;
  logic [2:0]  portCount;
  logic [15:0] chars;
  logic [3:0]  physMap;

  assign isShort = fmt_r == FMT_SHORT;
  assign isExt   = fmt_r == FMT_EXT;
  assign optByte = isShort ? img_r[B_OPT] : isExt ? img_r[X_OPT] : DEF_OPT;
  assign polByte = isExt ? img_r[X_POL] : DEF_POL;
  assign ocByte  = (isShort || isExt) ? img_r[B_OC] : DEF_OC; // RULE5
  assign langCnt = isExt ? img_r[X_LANG] : 8'h00;
  // Full-speed restriction overrides the link's own speed.
  assign speedHs = ctrl_r[CTRL_HS] && !optByte[OPT_FS_ONLY]; // RULE14

  always_comb
  begin
    if (isShort)
      portByte = img_r[B_PORTS]; // RULE6
    else if (isExt)
      portByte = {img_r[X_ACTIVE][3:0], img_r[X_REMOV][3:0]};
    else
      portByte = DEF_PORTS;
  end

  ucfg_port_map u_map
  (
    .usableMask    (portByte[7:4]),
    .logicalMask   (portByte[3:0]),
    .portCount     (portCount), // RULE7
    .physRemovable (physMap) // RULE8
  );

  always_comb
  begin
    chars = 16'h0000;
    chars[2] = optByte[OPT_COMPOUND]; // RULE13
    chars[7] = !optByte[OPT_NO_IND]; // RULE15
    if (optByte[OPT_GANGED])
      chars[1:0] = 2'b00; // RULE16
    else
      chars[1:0] = 2'b01;
    if (isExt)
      chars[4:3] = {polByte[POL_OCM1], polByte[POL_OCM2]}; // RULE19
    else if (optByte[OPT_GANGED])
      chars[4:3] = 2'b00;
    else
      chars[4:3] = 2'b01;
  end

  // -------------------------------------------------------------
  // Descriptor fields
  // -------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      desc     <= '0;
      cfgReady <= 1'b0;
    end
    else
    begin
      cfgReady <= state_r == ST_DONE;
      if (isShort || isExt)
      begin
        desc.vendorId  <= {img_r[B_VID_H], img_r[B_VID_L]}; // RULE2
        desc.productId <= {img_r[B_PID_H], img_r[B_PID_L]}; // RULE3
        desc.releaseHi <= img_r[B_DID_H]; // RULE4
      end
      else
      begin
        desc.vendorId  <= DEF_VID;
        desc.productId <= DEF_PID;
        desc.releaseHi <= DEF_DID;
      end
      desc.liveOcFilterMs     <= ocByte[7:4];
      desc.idleOcFilterMs     <= ocByte[3:0];
      desc.usablePortMask     <= portByte[7:4];
      desc.detachablePortMask <= portByte[3:0];
      desc.portCount          <= portCount;
      if (isShort)
      begin
        desc.upstreamCurrentUnits <= img_r[B_PWR]; // RULE9
        desc.controllerCurrentMa  <= img_r[B_CTRL]; // RULE10
        desc.portPowerGoodDelay   <= img_r[B_PGOOD]; // RULE11
      end
      else if (isExt)
      begin
        desc.upstreamCurrentUnits <= speedHs ? img_r[X_PWR_HS]
                                             : img_r[X_PWR_FS];
        case ({ctrl_r[CTRL_SELF], speedHs})
          2'b00:   desc.controllerCurrentMa <= img_r[X_CC_BFS];
          2'b01:   desc.controllerCurrentMa <= img_r[X_CC_BHS];
          2'b10:   desc.controllerCurrentMa <= img_r[X_CC_SFS];
          default: desc.controllerCurrentMa <= img_r[X_CC_SHS];
        endcase
        desc.portPowerGoodDelay <= img_r[X_PGOOD];
      end
      else
      begin
        desc.upstreamCurrentUnits <= speedHs ? DEF_PWR_HS : DEF_PWR_FS;
        desc.controllerCurrentMa  <= speedHs ? DEF_CC_HS : DEF_CC_FS;
        desc.portPowerGoodDelay   <= DEF_PGOOD;
      end
      desc.hubChars         <= chars;
      desc.fsRestrict       <= optByte[OPT_FS_ONLY];
      desc.indicatorsOff    <= optByte[OPT_NO_IND];
      desc.amberLedPolarity <= polByte[POL_AMBER];
      desc.greenLedPolarity <= polByte[POL_GREEN];
      desc.powerCtlPolarity <= polByte[POL_PWR];
      desc.ocInPolarity     <= polByte[POL_OC];
    end
  end

  // -------------------------------------------------------------
  // Strings and write protection
  // -------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stringsOn      <= 1'b0;
      mfrTableBase   <= LANG_BASE;
      tableStride    <= 10'h000;
      imageWriteLock <= 1'b0;
      physRemovable  <= 4'h0;
    end
    else
    begin
      stringsOn    <= langCnt != 8'h00 && langCnt <= LANG_MAX; // RULE21
      tableStride  <= {1'b0, langCnt, 1'b0};
      mfrTableBase <= LANG_BASE + {1'b0, langCnt, 1'b0}; // RULE22
      imageWriteLock <= isExt && img_r[X_WP] == WP_KEY; // RULE20
      physRemovable  <= physMap; // RULE8
    end
  end

  // -------------------------------------------------------------
  // Hub descriptor request check
  // -------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      descAccept <= 1'b0;
      descStall  <= 1'b0;
    end
    else
    begin
      // Type 0x00 is tolerated only when the option allows it.
      descAccept <= descReq && (descType == HUB_DESC ||
                    (descType == ZERO_DESC &&
                     optByte[OPT_ZERO_DESC])); // RULE12
      descStall  <= descReq && !(descType == HUB_DESC ||
                    (descType == ZERO_DESC &&
                     optByte[OPT_ZERO_DESC])); // RULE12
    end
  end

  // -------------------------------------------------------------
  // Register port
  // -------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      ctrl_r <= 3'h0;
    else if (regWr && regAddr == REG_CTRL)
      ctrl_r <= {regWdata[CTRL_SELF], regWdata[CTRL_HS], 1'b0};
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      regRdata <= 32'h0000_0000;
    else if (regRd)
    begin
      case (regAddr)
        REG_CTRL:   regRdata <= {29'h0, ctrl_r[2:1], 1'b0};
        REG_STATUS: regRdata <= {26'h0, imageWriteLock, stringsOn,
                                 fmt_r, state_r == ST_DONE, 1'b0};
        REG_IDS:    regRdata <= {desc.productId, desc.vendorId};
        REG_POWER:  regRdata <= {desc.releaseHi, desc.portPowerGoodDelay,
                                 desc.controllerCurrentMa,
                                 desc.upstreamCurrentUnits};
        REG_HUB:    regRdata <= {desc.hubChars, ocByte, 1'b0,
                                 portCount, physRemovable};
        REG_STRING: regRdata <= {12'h0, tableStride, mfrTableBase};
        default:    regRdata <= 32'h0000_0000;
      endcase
    end
    else
      regRdata <= 32'h0000_0000;
  end
endmodule
`default_nettype wire

// [ucfg_loader_monitor.sv]
`default_nettype none
module ucfg_loader_monitor
(
  // Clock and reset
  input wire logic                 clock,
  input wire logic                 sys_rst,
  // Image fetch
  input wire ucfg_pkg::ucfg_fetch_t fetch,
  input wire logic                 fetchValid,
  input wire logic [7:0]           fetchData,
  // Descriptor check
  input wire logic                 descReq,
  input wire logic [7:0]           descType,
  input wire logic                 descAccept,
  input wire logic                 descStall,
  // Decoded fields
  input wire ucfg_pkg::ucfg_desc_t desc,
  input wire logic                 cfgReady,
  input wire logic                 stringsOn,
  input wire logic [9:0]           mfrTableBase,
  input wire logic [9:0]           tableStride,
  input wire logic [3:0]           physRemovable,
  // Register port
  input wire logic [7:0]           regAddr,
  input wire logic                 regRd,
  input wire logic [31:0]          regRdata
);
  import ucfg_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------
  // Load sequence
  // ---------------------------------------------------------
  a_load_start: assert property ($fell(sys_rst) |-> ##[0:2] (fetch.req && fetch.addr == 8'h00)) else $error("load did not start at byte zero");
  a_fetch_seq: assert property (fetch.req && fetch.addr != 8'h00 |-> fetch.addr == $past(fetch.addr) + 8'h01) else $error("image not read in order");
  a_req_pulse: assert property (fetch.req |=> !fetch.req) else $error("fetch request too long");
  a_bad_sig: assert property (fetchValid && fetch.addr == 8'h00 && fetchData != SIG_SHORT && fetchData != SIG_EXT |=> !fetch.req [*4]) else $error("load went on after unknown signature");
  // ---------------------------------------------------------
  // Descriptor requests and fields
  // ---------------------------------------------------------
  a_desc_once: assert property (descReq |=> descAccept != descStall) else $error("descriptor answer missing");
  a_hub_type: assert property (descReq && descType == HUB_DESC |=> descAccept) else $error("hub descriptor refused");
  a_bad_type: assert property (descReq && descType != HUB_DESC && descType != ZERO_DESC |=> descStall) else $error("bad type not stalled");
  a_port_count: assert property (cfgReady |-> desc.portCount == 3'($countones(desc.usablePortMask))) else $error("port count wrong");
  a_ind_char: assert property (cfgReady |-> desc.hubChars[7] == !desc.indicatorsOff) else $error("indicator bit wrong");
  a_remov_map: assert property (cfgReady |-> (physRemovable & ~desc.usablePortMask) == 4'h0) else $error("removable on absent port");
  a_id_read: assert property (regRd && regAddr == REG_IDS |=> regRdata == {desc.productId, desc.vendorId}) else $error("id read differs");
  a_ids_hold: assert property (cfgReady && $past(cfgReady) |-> $stable({desc.vendorId, desc.productId, desc.hubChars})) else $error("stored fields moved");
  a_table_base: assert property (stringsOn |-> mfrTableBase == LANG_BASE + tableStride) else $error("table base wrong");
endmodule
bind ucfg_loader ucfg_loader_monitor i_ucfg_loader_monitor
(
  .clock(clock), .sys_rst(sys_rst), .fetch(fetch),
  .fetchValid(fetchValid), .fetchData(fetchData), .descReq(descReq),
  .descType(descType), .descAccept(descAccept), .descStall(descStall),
  .desc(desc), .cfgReady(cfgReady), .stringsOn(stringsOn),
  .mfrTableBase(mfrTableBase), .tableStride(tableStride),
  .physRemovable(physRemovable), .regAddr(regAddr), .regRd(regRd),
  .regRdata(regRdata)
);
`default_nettype wire

// [ucfg_pkg.sv]
`default_nettype none
package ucfg_pkg;
  // -------------------------------------------------------------
  // Image layout
  // -------------------------------------------------------------
  localparam logic [7:0] SIG_SHORT    = 8'hd2;
  localparam logic [7:0] SIG_EXT      = 8'hd4;
  localparam logic [7:0] WP_KEY       = 8'h42;
  localparam int         IMG_BYTES    = 24;
  localparam logic [7:0] LAST_SHORT   = 8'h0c;
  localparam logic [7:0] LAST_EXT     = 8'h17;
  localparam int B_VID_L = 1;
  localparam int B_VID_H = 2;
  localparam int B_PID_L = 3;
  localparam int B_PID_H = 4;
  localparam int B_DID_H = 6;
  localparam int B_OC    = 7;
  localparam int B_PORTS = 8;
  localparam int B_PWR   = 9;
  localparam int B_CTRL  = 10;
  localparam int B_PGOOD = 11;
  localparam int B_OPT   = 12;
  localparam int X_PWR_FS  = 8;
  localparam int X_PWR_HS  = 9;
  localparam int X_CC_BFS  = 12;
  localparam int X_CC_BHS  = 13;
  localparam int X_CC_SFS  = 14;
  localparam int X_CC_SHS  = 15;
  localparam int X_PGOOD   = 16;
  localparam int X_OPT     = 17;
  localparam int X_POL     = 18;
  localparam int X_WP      = 19;
  localparam int X_LANG    = 20;
  localparam int X_ACTIVE  = 22;
  localparam int X_REMOV   = 23;
  localparam logic [9:0] LANG_BASE = 10'h018;
  localparam logic [7:0] LANG_MAX  = 8'h1f;
  // Option byte bit positions.
  localparam int OPT_ZERO_DESC = 7;
  localparam int OPT_COMPOUND  = 6;
  localparam int OPT_FS_ONLY   = 5;
  localparam int OPT_NO_IND    = 4;
  localparam int OPT_GANGED    = 2;
  // Polarity byte bit positions.
  localparam int POL_AMBER = 7;
  localparam int POL_GREEN = 6;
  localparam int POL_PWR   = 3;
  localparam int POL_OC    = 2;
  localparam int POL_OCM1  = 1;
  localparam int POL_OCM2  = 0;
  // -------------------------------------------------------------
  // Built-in defaults
  // -------------------------------------------------------------
  localparam logic [7:0] DEF_OC       = 8'h88;
  localparam logic [7:0] DEF_PORTS    = 8'hff;
  localparam logic [7:0] DEF_PWR_FS   = 8'h28;
  localparam logic [7:0] DEF_PWR_HS   = 8'h57;
  localparam logic [7:0] DEF_CC_FS    = 8'h50;
  localparam logic [7:0] DEF_CC_HS    = 8'hae;
  localparam logic [7:0] DEF_PGOOD    = 8'h32;
  localparam logic [7:0] DEF_OPT      = 8'h80;
  localparam logic [7:0] DEF_POL      = 8'hcc;
  // Arbitrary neutral identity values.
  localparam logic [15:0] DEF_VID     = 16'h0000;
  localparam logic [15:0] DEF_PID     = 16'h0000;
  localparam logic [7:0]  DEF_DID     = 8'h00;
  localparam logic [7:0]  HUB_DESC    = 8'h29;
  localparam logic [7:0]  ZERO_DESC   = 8'h00;
  // -------------------------------------------------------------
  // Register map
  // -------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IDS    = 8'h08;
  localparam logic [7:0] REG_POWER  = 8'h0c;
  localparam logic [7:0] REG_HUB    = 8'h10;
  localparam logic [7:0] REG_STRING = 8'h14;
  localparam int CTRL_RELOAD = 0;
  localparam int CTRL_HS     = 1;
  localparam int CTRL_SELF   = 2;

  typedef enum logic [1:0]
  {
    FMT_NONE  = 2'h0,
    FMT_SHORT = 2'h1,
    FMT_EXT   = 2'h2
  } ucfg_fmt_t;

  typedef struct packed
  {
    logic [7:0] addr;
    logic       req;
  } ucfg_fetch_t;

  typedef struct packed
  {
    logic [15:0] vendorId;
    logic [15:0] productId;
    logic [7:0]  releaseHi;
    logic [3:0]  liveOcFilterMs;
    logic [3:0]  idleOcFilterMs;
    logic [3:0]  usablePortMask;
    logic [3:0]  detachablePortMask;
    logic [2:0]  portCount;
    logic [7:0]  upstreamCurrentUnits;
    logic [7:0]  controllerCurrentMa;
    logic [7:0]  portPowerGoodDelay;
    logic [15:0] hubChars;
    logic        fsRestrict;
    logic        indicatorsOff;
    logic        amberLedPolarity;
    logic        greenLedPolarity;
    logic        powerCtlPolarity;
    logic        ocInPolarity;
  } ucfg_desc_t;
endpackage
`default_nettype wire

// [ucfg_port_map.sv]
`default_nettype none
module ucfg_port_map
(
  // Masks
  input  wire logic [3:0] usableMask,
  input  wire logic [3:0] logicalMask,
  // Results
  output logic      [2:0] portCount,
  output logic      [3:0] physRemovable
);
  import ucfg_pkg::*;

  // Physical port p takes the logical slot equal to the usable ports
  // below it, so disabled ports leave no holes in the numbering.
  always_comb
  begin
    logic [2:0] slot;
    slot = 3'h0;
    physRemovable = 4'h0;
    for (int p = 0; p < 4; p++)
    begin
      if (usableMask[p])
      begin
        physRemovable[p] = logicalMask[slot[1:0]];
        slot = slot + 3'h1;
      end
    end
    portCount = slot;
  end
endmodule
`default_nettype wire
